// ---- verilog/ptm_array.sv ----
// Our own choices: the register offsets and the plain strobed port.
`timescale 1ns/1ps

module ptm_array
    import ptm_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic [NUM_IN-1:0] localIn,
    input  wire logic [NUM_GLB-1:0] globalIn,
    input  wire logic [NUM_DED-1:0] dedClkIn,
    input  wire logic              chipWideClearN,
    input  wire logic [ADDR_W-1:0] regAddr,
    input  wire logic [DATA_W-1:0] regWrData,
    input  wire logic              regWr,
    input  wire logic              regRd,
    output logic [DATA_W-1:0]      regRdData,
    output logic [NUM_CELL-1:0]    cellOut
);

    // Pin synchroniser, product-term store and configuration.
    logic [PIN_W-1:0]      syncA_r;
    logic [PIN_W-1:0]      syncB_r;
    logic [LIT_W-1:0]      ptMask_r [NUM_TERM];
    logic [CELL_CFG_W-1:0] cellCfg_r [NUM_CELL];
    logic [CLK_CFG_W-1:0]  clkCfg_r [NUM_BCLK];
    logic [CLR_CFG_W-1:0]  clrCfg_r;
    logic [NUM_BCLK-1:0]   srcPrev_r;
    logic [NUM_CELL-1:0]   cellOut_r;
    logic [DATA_W-1:0]     rdData_r;

    // Synchronised views of the outside signals.
    logic [NUM_IN-1:0]  locSync;
    logic [NUM_GLB-1:0] glbSync;
    logic [NUM_DED-1:0] dedSync;
    logic               chipClrNSync;

    assign locSync      = syncB_r[NUM_IN-1:0];
    assign glbSync      = syncB_r[NUM_IN +: NUM_GLB];
    assign dedSync      = syncB_r[NUM_IN+NUM_GLB +: NUM_DED];
    assign chipClrNSync = syncB_r[PIN_W-1];

    // Literal plane: local inputs and fed-back cells, true and complement.
    logic [SIG_W-1:0] sigVec;
    logic [LIT_W-1:0] literals;

    assign sigVec   = {cellOut_r[NUM_FB-1:0], locSync};
    assign literals = {~sigVec, sigVec};

    // Block clocks: edge of the chosen source gated by its paired enable.
    logic [NUM_BCLK-1:0] srcLvl;
    logic [NUM_BCLK-1:0] enLvl;
    logic [NUM_BCLK-1:0] tick;

    for (genvar k = 0; k < NUM_BCLK; k++) begin : g_bclk
        ptm_clksrc_t kind;
        logic [4:0]  idx;
        logic [4:0]  enIdx;
        logic        rise;
        logic        edgeSeen;

        assign kind  = ptm_clksrc_t'(clkCfg_r[k][CLK_KIND_POS +: 2]);
        assign idx   = clkCfg_r[k][CLK_IDX_POS +: 5];
        assign enIdx = clkCfg_r[k][CLK_EN_IDX_POS +: 5];
        assign rise  = clkCfg_r[k][CLK_RISE];
        assign srcLvl[k] = (kind == PTM_SRC_PIN) ? dedSync[idx[0]] :
                           (kind == PTM_SRC_GLB) ? glbSync[idx[1:0]] :
                           (kind == PTM_SRC_LOC) ? locSync[idx] : 1'b0;
        assign enLvl[k]  = clkCfg_r[k][CLK_ENUSE] ? locSync[enIdx] : 1'b1;
        // Each block clock carries one polarity, so mixed-edge use takes both.
        assign edgeSeen  = rise ? (srcLvl[k] & ~srcPrev_r[k])
                                : (~srcLvl[k] & srcPrev_r[k]);
        assign tick[k]   = edgeSeen & enLvl[k];
    end

    // Block clears from global or local lines, each optionally inverted.
    logic [NUM_CLR-1:0] clrLvl;
    logic               chipClr;

    for (genvar c = 0; c < NUM_CLR; c++) begin : g_clr
        logic       fromLocal;
        logic [4:0] idx;
        logic       inv;

        assign fromLocal = clrCfg_r[c*CLR_STRIDE + CLR_KIND];
        assign idx       = clrCfg_r[c*CLR_STRIDE + CLR_IDX_POS +: 5];
        assign inv       = clrCfg_r[c*CLR_STRIDE + CLR_INV];
        assign clrLvl[c] = (fromLocal ? locSync[idx] : glbSync[idx[1:0]]) ^ inv;
    end

    assign chipClr = clrCfg_r[CLR_CHIP_EN] & ~chipClrNSync;

    // Macrocells with the expander chain running from cell 0 upward.
    logic [NUM_CELL:0]   expChain;
    logic [NUM_CELL-1:0] cellVal;

    assign expChain[0] = 1'b0;

    for (genvar m = 0; m < NUM_CELL; m++) begin : g_cell
        ptm_macrocell u_cell (
            .clk      (clk),
            .rst      (rst),
            .literals (literals),
            .mask0    (ptMask_r[2*m]),
            .mask1    (ptMask_r[2*m+1]),
            .cfg      (cellCfg_r[m]),
            .tick     (tick),
            .clrLvl   (clrLvl),
            .chipClr  (chipClr),
            .expIn    (expChain[m]),
            .expOut   (expChain[m+1]),
            .cellVal  (cellVal[m])
        );
    end

    // Register port decode.
    logic       ptHit;
    logic [4:0] ptTerm;
    logic [1:0] ptWord;
    logic       cellHit;
    logic [3:0] cellIdx;
    logic       clkHit;
    logic       clrHit;

    assign ptHit   = ~regAddr[ADDR_W-1] & (regAddr[1:0] != PT_WORDS);
    assign ptTerm  = regAddr[6:2];
    assign ptWord  = regAddr[1:0];
    assign cellHit = regAddr[ADDR_W-1:4] == ADDR_CELL_BASE[ADDR_W-1:4];
    assign cellIdx = regAddr[3:0];
    assign clkHit  = (regAddr == ADDR_CLK0) | (regAddr == ADDR_CLK1);
    assign clrHit  = regAddr == ADDR_CLR;

    // Read data selection.
    logic [LIT_W-1:0]  rdMask;
    logic [DATA_W-1:0] ptRdWord;
    logic [DATA_W-1:0] rdMux;

    assign rdMask   = ptMask_r[ptTerm];
    assign ptRdWord = (ptWord == 2'h0) ? rdMask[31:0] :
                      (ptWord == 2'h1) ? rdMask[63:32] :
                      {{(3*DATA_W-LIT_W){1'b0}}, rdMask[LIT_W-1:64]};
    assign rdMux    = ptHit                      ? ptRdWord :
                      cellHit                    ? {19'h00000, cellCfg_r[cellIdx]} :
                      (regAddr == ADDR_CLK0)     ? {18'h00000, clkCfg_r[0]} :
                      (regAddr == ADDR_CLK1)     ? {18'h00000, clkCfg_r[1]} :
                      clrHit                     ? {15'h0000, clrCfg_r} :
                      (regAddr == ADDR_CELL_STAT) ? {16'h0000, cellOut_r} :
                      (regAddr == ADDR_IN_STAT)  ? locSync : 32'h00000000;

    // Outside signals cross into the clock domain through two flops.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            syncA_r <= '0;
            syncB_r <= '0;
        end else begin
            syncA_r <= {chipWideClearN, dedClkIn, globalIn, localIn};
            syncB_r <= syncA_r;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            srcPrev_r <= '0;
            cellOut_r <= '0;
        end else begin
            srcPrev_r <= srcLvl;
            cellOut_r <= cellVal;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int t = 0; t < NUM_TERM; t++) begin
                ptMask_r[t] <= '0;
            end
        end else if (regWr && ptHit) begin
            unique case (ptWord)
                2'h0:    ptMask_r[ptTerm][31:0]      <= regWrData;
                2'h1:    ptMask_r[ptTerm][63:32]     <= regWrData;
                default: ptMask_r[ptTerm][LIT_W-1:64] <= regWrData[LIT_W-65:0];
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int m = 0; m < NUM_CELL; m++) begin
                cellCfg_r[m] <= CELL_CFG_RST;
            end
        end else if (regWr && cellHit) begin
            cellCfg_r[cellIdx] <= regWrData[CELL_CFG_W-1:0];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            clkCfg_r[0] <= CLK0_CFG_RST;
            clkCfg_r[1] <= CLK1_CFG_RST;
            clrCfg_r    <= CLR_CFG_RST;
        end else if (regWr && clkHit) begin
            clkCfg_r[regAddr[0]] <= regWrData[CLK_CFG_W-1:0];
        end else if (regWr && clrHit) begin
            clrCfg_r <= regWrData[CLR_CFG_W-1:0];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdData_r <= '0;
        end else if (regRd) begin
            rdData_r <= rdMux;
        end else begin
            rdData_r <= '0;
        end
    end

    assign regRdData = rdData_r;
    assign cellOut   = cellOut_r;

endmodule

// ---- shared/ptm_pkg.sv ----
package ptm_pkg;

    // Array dimensions.
    localparam int NUM_IN     = 32;
    localparam int NUM_FB     = 9;
    localparam int NUM_CELL   = 16;
    localparam int NUM_TERM   = 2 * NUM_CELL;
    localparam int NUM_GLB    = 4;
    localparam int NUM_DED    = 2;
    localparam int NUM_BCLK   = 2;
    localparam int NUM_CLR    = 2;
    localparam int SIG_W      = NUM_IN + NUM_FB;
    localparam int LIT_W      = 2 * SIG_W;
    localparam int PIN_W      = NUM_IN + NUM_GLB + NUM_DED + 1;
    localparam int ADDR_W     = 8;
    localparam int DATA_W     = 32;
    localparam int CELL_CFG_W = 13;
    localparam int CLK_CFG_W  = 14;
    localparam int CLR_CFG_W  = 17;

    // Register map, word addresses on the configuration port.
    localparam logic [ADDR_W-1:0] ADDR_CELL_BASE = 8'h80;
    localparam logic [ADDR_W-1:0] ADDR_CLK0      = 8'hA0;
    localparam logic [ADDR_W-1:0] ADDR_CLK1      = 8'hA1;
    localparam logic [ADDR_W-1:0] ADDR_CLR       = 8'hA2;
    localparam logic [ADDR_W-1:0] ADDR_CELL_STAT = 8'hA3;
    localparam logic [ADDR_W-1:0] ADDR_IN_STAT   = 8'hA4;
    localparam logic [1:0]        PT_WORDS       = 2'h3;

    // Macrocell configuration fields.
    localparam int MC_MODE_POS   = 0;
    localparam int MC_BYPASS     = 2;
    localparam int MC_CLKSEL     = 3;
    localparam int MC_CLRSEL_POS = 4;
    localparam int MC_T0EXP      = 6;
    localparam int MC_T1EXP      = 7;
    localparam int MC_T1INV      = 8;
    localparam int MC_XOR_POS    = 9;
    localparam int MC_CHAIN_IN   = 11;
    localparam int MC_EXP_FWD    = 12;

    // Block clock configuration fields.
    localparam int CLK_KIND_POS   = 0;
    localparam int CLK_IDX_POS    = 2;
    localparam int CLK_RISE       = 7;
    localparam int CLK_ENUSE      = 8;
    localparam int CLK_EN_IDX_POS = 9;

    // Clear configuration fields; the second clear sits one stride higher.
    localparam int CLR_KIND     = 0;
    localparam int CLR_IDX_POS  = 1;
    localparam int CLR_INV      = 6;
    localparam int CLR_STRIDE   = 8;
    localparam int CLR_CHIP_EN  = 16;

    // Reset values.
    localparam logic [CELL_CFG_W-1:0] CELL_CFG_RST = 13'h0000;
    localparam logic [CLK_CFG_W-1:0]  CLK0_CFG_RST = 14'h0080;
    localparam logic [CLK_CFG_W-1:0]  CLK1_CFG_RST = 14'h0000;
    localparam logic [CLR_CFG_W-1:0]  CLR_CFG_RST  = 17'h00000;

    typedef enum logic [1:0] {
        PTM_REG_D  = 2'h0,
        PTM_REG_T  = 2'h1,
        PTM_REG_JK = 2'h3,
        PTM_REG_SR = 2'h2
    } ptm_regmode_t;

    typedef enum logic [1:0] {
        PTM_SRC_PIN = 2'h0,
        PTM_SRC_GLB = 2'h1,
        PTM_SRC_LOC = 2'h2,
        PTM_SRC_OFF = 2'h3
    } ptm_clksrc_t;

    typedef enum logic [1:0] {
        PTM_CLR_NONE = 2'h0,
        PTM_CLR_A    = 2'h1,
        PTM_CLR_B    = 2'h2,
        PTM_CLR_OFF  = 2'h3
    } ptm_clrsel_t;

    typedef enum logic [1:0] {
        PTM_XOR_ZERO  = 2'h0,
        PTM_XOR_ONE   = 2'h1,
        PTM_XOR_TERM1 = 2'h2,
        PTM_XOR_RSVD  = 2'h3
    } ptm_xorsel_t;

endpackage

// ---- verilog/ptm_macrocell.sv ----
`timescale 1ns/1ps

module ptm_macrocell
    import ptm_pkg::*;
(
    input  wire logic                  clk,
    input  wire logic                  rst,
    input  wire logic [LIT_W-1:0]      literals,
    input  wire logic [LIT_W-1:0]      mask0,
    input  wire logic [LIT_W-1:0]      mask1,
    input  wire logic [CELL_CFG_W-1:0] cfg,
    input  wire logic [NUM_BCLK-1:0]   tick,
    input  wire logic [NUM_CLR-1:0]    clrLvl,
    input  wire logic                  chipClr,
    input  wire logic                  expIn,
    output logic                       expOut,
    output logic                       cellVal
);

    logic         q_r;
    logic         q_nxt;
    ptm_regmode_t mode;
    ptm_xorsel_t  xorSel;
    ptm_clrsel_t  clrSel;
    logic         term0;
    logic         term1Raw;
    logic         term1;
    logic         dualIn;
    logic         t0Prim;
    logic         t1Prim;
    logic         chainIn;
    logic         orOut;
    logic         xorOp;
    logic         xorOut;
    logic         clrHit;
    logic         tickSel;

    assign mode     = ptm_regmode_t'(cfg[MC_MODE_POS +: 2]);
    assign xorSel   = ptm_xorsel_t'(cfg[MC_XOR_POS +: 2]);
    assign clrSel   = ptm_clrsel_t'(cfg[MC_CLRSEL_POS +: 2]);
    // An empty term is unused and reads low.
    assign term0    = (|mask0) & ((literals & mask0) == mask0);
    assign term1Raw = (|mask1) & ((literals & mask1) == mask1);
    assign term1    = term1Raw ^ cfg[MC_T1INV];
    assign dualIn   = (mode == PTM_REG_JK) || (mode == PTM_REG_SR);
    assign t0Prim   = ~cfg[MC_T0EXP];
    assign t1Prim   = ~cfg[MC_T1EXP] & ~dualIn & (xorSel != PTM_XOR_TERM1);
    assign chainIn  = cfg[MC_CHAIN_IN] & expIn;
    assign expOut   = (cfg[MC_T0EXP] & term0) | (cfg[MC_T1EXP] & term1)
                    | (cfg[MC_EXP_FWD] & expIn);
    assign orOut    = (t0Prim & term0) | (t1Prim & term1) | chainIn;
    assign xorOp    = (xorSel == PTM_XOR_ONE)
                    | ((xorSel == PTM_XOR_TERM1) & ~dualIn & term1);
    assign xorOut   = orOut ^ xorOp;
    assign clrHit   = ((clrSel == PTM_CLR_A) & clrLvl[0])
                    | ((clrSel == PTM_CLR_B) & clrLvl[1]);
    assign tickSel  = tick[cfg[MC_CLKSEL]];
    assign cellVal  = cfg[MC_BYPASS] ? xorOut : q_r;

    // In JK and SR modes the second term drives K or R.
    always_comb begin
        unique case (mode)
            PTM_REG_D:  q_nxt = xorOut;
            PTM_REG_T:  q_nxt = q_r ^ xorOut;
            PTM_REG_JK: q_nxt = (xorOut & ~q_r) | (~term1 & q_r);
            PTM_REG_SR: q_nxt = xorOut | (q_r & ~term1);
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            q_r <= 1'b0;
        end else if (chipClr) begin
            q_r <= 1'b0;
        end else if (clrHit) begin
            q_r <= 1'b0;
        end else if (tickSel) begin
            q_r <= q_nxt;
        end
    end

endmodule

// ---- tb/ptm_array_monitor.sv ----
`timescale 1ns/1ps

module ptm_array_monitor
    import ptm_pkg::*;
(
    input wire logic                clk,
    input wire logic                rst,
    input wire logic [NUM_IN-1:0]   localIn,
    input wire logic [NUM_GLB-1:0]  globalIn,
    input wire logic [NUM_DED-1:0]  dedClkIn,
    input wire logic                chipWideClearN,
    input wire logic [ADDR_W-1:0]   regAddr,
    input wire logic [DATA_W-1:0]   regWrData,
    input wire logic                regWr,
    input wire logic                regRd,
    input wire logic [DATA_W-1:0]   regRdData,
    input wire logic [NUM_CELL-1:0] cellOut
);
    // Shadows of the chip clear enable and bypass bits, and a count of quiet cycles.
    logic                chipEn_r;
    logic [NUM_CELL-1:0] bypass_r;
    logic [3:0]          quiet_r;
    logic [NUM_IN+6:0]   prevIn_r;
    wire  [NUM_IN+6:0]   curIn = {localIn, globalIn, dedClkIn, chipWideClearN};
    wire                 busy  = regWr || (curIn != prevIn_r);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            chipEn_r <= 1'b0;
            bypass_r <= '0;
            quiet_r  <= 4'h0;
            prevIn_r <= '0;
        end else begin
            if (regWr && regAddr == ADDR_CLR) begin
                chipEn_r <= regWrData[CLR_CHIP_EN];
            end
            if (regWr && regAddr[ADDR_W-1:4] == ADDR_CELL_BASE[ADDR_W-1:4]) begin
                bypass_r[regAddr[3:0]] <= regWrData[MC_BYPASS];
            end
            quiet_r  <= busy ? 4'h0 : quiet_r + {3'h0, quiet_r != 4'hF};
            prevIn_r <= curIn;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence clrHeld;
        (chipEn_r && !chipWideClearN) [*4];
    endsequence

    sequence rdOf(logic [ADDR_W-1:0] a);
        regRd && regAddr == a;
    endsequence

    rdIdle_a: assert property (!regRd |=> regRdData == '0)
        else $error("Read data not zero outside a read answer");
    statRd_a: assert property (rdOf(ADDR_CELL_STAT)
        |=> regRdData == {16'h0000, $past(cellOut)})
        else $error("Cell status read does not match outputs");
    inStat_a: assert property (rdOf(ADDR_IN_STAT) |=> regRdData == $past(localIn, 3))
        else $error("Input status read does not match local lines");
    unmapHi_a: assert property (regRd && regAddr > ADDR_IN_STAT |=> regRdData == '0)
        else $error("Unmapped read returned data");
    ptGap_a: assert property (regRd && regAddr < ADDR_CELL_BASE && regAddr[1:0] == 2'h3
        |=> regRdData == '0)
        else $error("Unused term word returned data");
    chipClr_a: assert property (clrHeld |=> (cellOut & ~bypass_r) == '0)
        else $error("Chip clear did not clear the cells");
    rstOut_a: assert property ($fell(rst) |-> cellOut == '0 && regRdData == '0)
        else $error("Outputs not zero after reset");
    quietHold_a: assert property (quiet_r == 4'hF |-> $stable(cellOut))
        else $error("Cell output moved without any cause");
endmodule

bind ptm_array ptm_array_monitor i_ptm_array_monitor (
    .clk(clk), .rst(rst), .localIn(localIn), .globalIn(globalIn), .dedClkIn(dedClkIn),
    .chipWideClearN(chipWideClearN), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .cellOut(cellOut)
);

// ---- tb/ptm_fabric_model.sv ----
`timescale 1ns/1ps

module ptm_fabric_model
    import ptm_pkg::*;
(
    input  wire logic               clk,
    input  wire logic               rst,
    input  wire logic [NUM_IN-1:0]  locV,
    input  wire logic [NUM_GLB-1:0] glbV,
    input  wire logic [NUM_DED-1:0] pinV,
    input  wire logic               clrNV,
    output logic      [NUM_IN-1:0]  localIn,
    output logic      [NUM_GLB-1:0] globalIn,
    output logic      [NUM_DED-1:0] dedClkIn,
    output logic                    chipWideClearN
);
    // Neighbouring logic launches its lines just after each rising edge.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            localIn        <= '0;
            globalIn       <= '0;
            dedClkIn       <= '0;
            chipWideClearN <= 1'b1;
        end else begin
            localIn        <= locV;
            globalIn       <= glbV;
            dedClkIn       <= pinV;
            chipWideClearN <= clrNV;
        end
    end
endmodule

// ---- tb/ptm_array_tb.sv ----
`timescale 1ns/1ps

module ptm_array_tb
    import ptm_pkg::*;
;
    logic                clk;
    logic                rst;
    logic                regWr;
    logic                regRd;
    logic                clrNV;
    logic                chipWideClearN;
    logic [ADDR_W-1:0]   regAddr;
    logic [DATA_W-1:0]   regWrData;
    logic [DATA_W-1:0]   regRdData;
    logic [NUM_IN-1:0]   locV;
    logic [NUM_IN-1:0]   localIn;
    logic [NUM_GLB-1:0]  glbV;
    logic [NUM_GLB-1:0]  globalIn;
    logic [NUM_DED-1:0]  pinV;
    logic [NUM_DED-1:0]  dedClkIn;
    logic [NUM_CELL-1:0] cellOut;
    int                  err_count;
    int                  n_checks;
    int                  cyc;

    ptm_fabric_model i_ptm_fabric_model (.clk(clk), .rst(rst), .locV(locV), .glbV(glbV),
        .pinV(pinV), .clrNV(clrNV), .localIn(localIn), .globalIn(globalIn),
        .dedClkIn(dedClkIn), .chipWideClearN(chipWideClearN));

    ptm_array i_ptm_array (.clk(clk), .rst(rst), .localIn(localIn), .globalIn(globalIn),
        .dedClkIn(dedClkIn), .chipWideClearN(chipWideClearN), .regAddr(regAddr),
        .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
        .cellOut(cellOut));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic summarize();
        $display("Checks %0d, errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: saw %h, expected %h", $time, got, exp);
        end
    endtask

    task automatic wt(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        regWr     <= 1'b1;
        regAddr   <= a;
        regWrData <= d;
        @(posedge clk);
        regWr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        regRd   <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRd <= 1'b0;
        #1;
        chk(regRdData, e);
    endtask

    task automatic cells(input logic [15:0] e, input int n);
        wt(n);
        #1;
        chk({16'h0000, cellOut}, {16'h0000, e});
    endtask

    // One slow pin clock pulse, checked after the rising and the falling half.
    task automatic pulse(input int k, input logic [15:0] mid, input logic [15:0] e);
        pinV[k] <= 1'b1;
        cells(mid, 6);
        pinV[k] <= 1'b0;
        cells(e, 6);
    endtask

    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            err_count++;
            summarize();
        end
    end

    initial begin
        rst       = 1'b1;
        regWr     = 1'b0;
        regRd     = 1'b0;
        regAddr   = '0;
        regWrData = '0;
        locV      = 32'h28;
        glbV      = '0;
        pinV      = '0;
        clrNV     = 1'b1;
        err_count = 0;
        n_checks  = 0;
        cyc       = 0;
        wt(5);
        rst <= 1'b0;
        rd(ADDR_CLK0, 32'h80);
        rd(ADDR_CLK1, 32'h0);
        rd(ADDR_CLR, 32'h0);
        rd(8'h8F, 32'h0);
        rd(ADDR_IN_STAT, 32'h28);
        rd(8'hA5, 32'h0);
        wr(8'h03, 32'hFFFF_FFFF);
        rd(8'h03, 32'h0);
        wr(ADDR_CELL_STAT, 32'hFFFF);
        rd(ADDR_CELL_STAT, 32'h0);
        wr(8'h7E, 32'hFFFF_FFFF);
        rd(8'h7E, 32'h3_FFFF);
        wr(8'h7E, 32'h0);
        wr(8'h00, 32'h8);
        wr(8'h81, 32'h211);
        wr(8'h82, 32'h208);
        wr(8'h88, 32'h200);
        wr(8'h89, 32'h201);
        wr(8'h8A, 32'h303);
        wr(8'h8B, 32'h302);
        wr(ADDR_CLK1, 32'h4);
        wr(ADDR_CLR, 32'h4B);
        rd(8'h8A, 32'h303);
        pulse(0, 16'h0F03, 16'h0F03);
        pulse(0, 16'h0901, 16'h0901);
        pulse(1, 16'h0901, 16'h0905);
        wr(ADDR_CLK0, 32'h980);
        pulse(0, 16'h0905, 16'h0905);
        locV <= 32'h38;
        wt(4);
        pulse(0, 16'h0F07, 16'h0F07);
        locV <= 32'h18;
        cells(16'h0F05, 8);
        pulse(0, 16'h0905, 16'h0905);
        locV <= 32'h38;
        wr(ADDR_CLR, 32'h1_004B);
        clrNV <= 1'b0;
        cells(16'h0000, 8);
        clrNV <= 1'b1;
        wr(8'h00, 32'h3);
        wr(8'h80, 32'h4);
        wr(8'h81, 32'h104);
        wr(8'h83, 32'h304);
        wr(8'h11, 32'h1);
        wr(8'h82, 32'h4);
        wr(8'h20, 32'h4);
        wr(8'h84, 32'h44);
        wr(8'h85, 32'h804);
        locV <= 32'h3F;
        cells(16'h0027, 10);
        locV <= 32'h38;
        cells(16'h0002, 10);
        wr(ADDR_CLK1, 32'h89);
        wr(ADDR_CLR, 32'h1_024B);
        wr(8'h30, 32'h8);
        wr(8'h34, 32'h2);
        wr(8'h85, 32'h1804);
        wr(8'h86, 32'h1428);
        wr(8'h87, 32'h804);
        glbV <= 4'h4;
        cells(16'h0042, 8);
        glbV <= 4'h6;
        cells(16'h0002, 8);
        glbV <= 4'h0;
        locV <= 32'h3C;
        cells(16'h00A2, 10);
        glbV <= 4'h4;
        cells(16'h00E2, 8);
        glbV <= 4'h0;
        locV <= 32'h3E;
        cells(16'h00E2, 10);
        glbV <= 4'h4;
        cells(16'h00A2, 8);
        wt(20);
        summarize();
    end
endmodule
